// *** include/peb_pkg.sv ***
package peb_pkg;
    // bus geometry
    localparam int PEB_ADDR_W = 17;
    localparam int PEB_DATA_W = 8;
    localparam int PEB_PAGE_LSB = 8;          // lowest page select bit
    localparam int PEB_TOGGLE_BIT = 6;        // toggle_status_bit position
    localparam int PEB_FIFO_DEPTH = 8;
    localparam int PEB_CLK_MHZ = 25;
    // timing in their own units
    localparam int PEB_POWERUP_READ_US = 100;
    localparam int PEB_WRITE_CYCLE_MS = 10;
    localparam int PEB_BYTE_LOAD_MAX_US = 100;
    localparam int PEB_READ_NS = 250;         // slowest read cycle grade
    localparam int PEB_WP_NS = 100;           // strobe pulse width
    localparam int PEB_WPH_NS = 100;          // strobe high recovery
    localparam int PEB_CLK_NS = 1000 / PEB_CLK_MHZ;
    // derived cycle counts: least times round up
    localparam int PEB_POWERUP_CYC = PEB_POWERUP_READ_US * PEB_CLK_MHZ;
    localparam int PEB_WRITE_CYCLE_CYC =
        PEB_WRITE_CYCLE_MS * 1000 * PEB_CLK_MHZ;
    // longest time rounds down, kept one below to stay inside the window
    localparam int PEB_BYTE_LOAD_CYC = PEB_BYTE_LOAD_MAX_US * PEB_CLK_MHZ - 1;
    localparam int PEB_READ_CYC = (PEB_READ_NS + PEB_CLK_NS - 1) / PEB_CLK_NS;
    localparam int PEB_WP_CYC = (PEB_WP_NS + PEB_CLK_NS - 1) / PEB_CLK_NS;
    localparam int PEB_WPH_CYC = (PEB_WPH_NS + PEB_CLK_NS - 1) / PEB_CLK_NS;
    localparam int PEB_CNT_W = 20;
    // command codes of the host request port
    localparam logic [1:0] PEB_CMD_READ = 2'h0;
    localparam logic [1:0] PEB_CMD_WRITE = 2'h1;
    localparam logic [1:0] PEB_CMD_POLL = 2'h2;
    localparam logic [1:0] PEB_CMD_WRITE_LAST = 2'h3;
    typedef enum logic [2:0] {
        PEB_PWRUP = 3'b000,
        PEB_IDLE = 3'b001,
        PEB_WR_LOW = 3'b011,
        PEB_WR_HIGH = 3'b010,
        PEB_RD = 3'b110,
        PEB_WAIT_WC = 3'b111,
        PEB_POLL_RD = 3'b101
    } peb_state_type;
endpackage

// *** hdl/peb_fifo.sv ***
`timescale 1ns/1ps
module peb_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic do_push;
    logic do_pop;

    localparam logic [AW:0] LAST_FREE = (AW + 1)'(DEPTH - 1);

    // out_valid straight from the occupancy count
    assign out_valid = (count_ff != '0);
    assign out_data = mem[rd_ptr_ff];
    assign do_push = clk_en && in_valid && in_ready;
    assign do_pop = clk_en && out_valid && out_ready;

    // storage has no reset, only the pointers, count and ready need one
    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // pointers wrap; depth is expected to be a power of two
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            in_ready <= 1'b1;
        end else begin
            if (do_push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            // ready is a flop so the caller never sees a comparator
            if (do_push && !do_pop) begin
                count_ff <= count_ff + 1'b1;
                in_ready <= (count_ff != LAST_FREE);
            end else if (do_pop && !do_push) begin
                count_ff <= count_ff - 1'b1;
                in_ready <= 1'b1;
            end
        end
    end
endmodule // peb_fifo

// *** hdl/peb_host.sv ***
`timescale 1ns/1ps
// How it works
// [RL1] drive select, output enable, strobe per mode
// [RL2] device finishes programming within write cycle
// [RL3] wait full cycle or poll toggle bit
// [RL4] page bits fixed across one page load
// [RL5] polls between byte loads keep page open; here a poll in an open page waits out the window and programming
// [RL6] each byte load uses strobe timing
// [RL7] polls run with ordinary read timing
// [RL8] hold off first read after power-up
// [RL9] strobe pulses kept well above glitch width
// [RL10] protected device relocks after each page
// [RL11] loads spaced inside the byte load window
module peb_host
    import peb_pkg::*;
#(
    parameter int POWERUP_CYC = PEB_POWERUP_CYC,
    parameter int WRITE_CYCLE_CYC = PEB_WRITE_CYCLE_CYC,
    parameter int BYTE_LOAD_CYC = PEB_BYTE_LOAD_CYC,
    parameter int DEPTH = PEB_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_cmd,
    input wire logic [PEB_ADDR_W-1:0] req_addr,
    input wire logic [PEB_DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [PEB_DATA_W-1:0] rsp_rdata,
    output logic rsp_done,
    output logic busy,
    output logic [PEB_ADDR_W-1:0] mem_addr,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic wr_strobe_n,
    input wire logic [PEB_DATA_W-1:0] data_in,
    output logic [PEB_DATA_W-1:0] data_out,
    output logic data_oe_n
);
    localparam int FW = 2 + PEB_ADDR_W + PEB_DATA_W;
    peb_state_type state_ff;
    logic [PEB_CNT_W-1:0] cnt_ff;
    logic [PEB_CNT_W-1:0] wc_cnt_ff;
    logic page_open_ff;
    logic [PEB_ADDR_W-1:PEB_PAGE_LSB] page_ff;
    logic toggle_ff;
    logic poll_armed_ff;
    logic [1:0] cmd_ff;
    logic f_valid;
    logic f_ready;
    logic [FW-1:0] f_data;
    logic [1:0] f_cmd;
    logic [PEB_ADDR_W-1:0] f_addr;
    logic [PEB_DATA_W-1:0] f_wdata;
    logic cnt_zero;
    logic page_match;
    logic can_write;

    // requests queue here so the caller stalls only once DEPTH requests wait
    peb_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data({req_cmd, req_addr, req_wdata}),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .out_data(f_data)
    );

    assign {f_cmd, f_addr, f_wdata} = f_data;
    assign cnt_zero = (cnt_ff == '0);
    // [RL4] page bits compared
    assign page_match = (f_addr[PEB_ADDR_W-1:PEB_PAGE_LSB] == page_ff);
    // [RL3] write cycle guard
    assign can_write = page_open_ff ? page_match : (wc_cnt_ff == '0);
    assign f_ready = (state_ff == PEB_IDLE) && f_valid && clk_en &&
        (f_cmd[0] == 1'b0 || can_write);

    // main sequencer over the parallel pins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff <= PEB_PWRUP;
            cnt_ff <= PEB_CNT_W'(POWERUP_CYC);
            cmd_ff <= PEB_CMD_READ;
        end else if (clk_en) begin
            unique case (state_ff)
                // [RL8] power-up hold off
                PEB_PWRUP: begin
                    if (cnt_zero) begin
                        state_ff <= PEB_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                PEB_IDLE: begin
                    if (f_ready) begin
                        cmd_ff <= f_cmd;
                        if (f_cmd[0]) begin
                            // [RL6] strobe low width
                            state_ff <= PEB_WR_LOW;
                            cnt_ff <= PEB_CNT_W'(PEB_WP_CYC - 1);
                        end else begin
                            // [RL7] read cycle timing
                            state_ff <= PEB_RD;
                            cnt_ff <= PEB_CNT_W'(PEB_READ_CYC - 1);
                        end
                    end
                end
                // [RL9] pulse width held
                PEB_WR_LOW: begin
                    if (cnt_zero) begin
                        state_ff <= PEB_WR_HIGH;
                        cnt_ff <= PEB_CNT_W'(PEB_WPH_CYC - 1);
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                PEB_WR_HIGH: begin
                    if (cnt_zero) begin
                        state_ff <= PEB_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                PEB_RD: begin
                    if (!cnt_zero) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end else if (cmd_ff == PEB_CMD_POLL && busy) begin
                        // [RL3] keep polling
                        state_ff <= PEB_WAIT_WC;
                        cnt_ff <= PEB_CNT_W'(PEB_WPH_CYC - 1);
                    end else begin
                        state_ff <= PEB_IDLE;
                    end
                end
                // gap between poll reads, select high
                PEB_WAIT_WC: begin
                    if (cnt_zero) begin
                        state_ff <= PEB_POLL_RD;
                        cnt_ff <= PEB_CNT_W'(PEB_READ_CYC - 1);
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                PEB_POLL_RD: begin
                    if (cnt_zero) begin
                        state_ff <= PEB_RD;
                        cnt_ff <= '0;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                default: begin
                    state_ff <= PEB_IDLE;
                end
            endcase
        end
    end

    // page window and write cycle timers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            page_open_ff <= 1'b0;
            page_ff <= '0;
            wc_cnt_ff <= '0;
            busy <= 1'b0;
        end else if (clk_en) begin
            if (state_ff == PEB_IDLE && f_ready && f_cmd[0]) begin
                page_ff <= f_addr[PEB_ADDR_W-1:PEB_PAGE_LSB];
                // [RL11] reopen byte load window
                page_open_ff <= (f_cmd == PEB_CMD_WRITE);
                // [RL10] last byte relocks
                // device may still wait out its own load window first
                wc_cnt_ff <= PEB_CNT_W'((f_cmd == PEB_CMD_WRITE) ?
                    BYTE_LOAD_CYC : BYTE_LOAD_CYC + WRITE_CYCLE_CYC);
                busy <= 1'b1;
            end else if (state_ff == PEB_RD && cnt_zero && poll_armed_ff &&
                    cmd_ff == PEB_CMD_POLL && busy && !page_open_ff &&
                    data_in[PEB_TOGGLE_BIT] == toggle_ff) begin
                // [RL2] toggle stopped over two reads, early completion
                wc_cnt_ff <= '0;
                busy <= 1'b0;
            end else if (wc_cnt_ff != '0) begin
                wc_cnt_ff <= wc_cnt_ff - 1'b1;
            end else if (page_open_ff) begin
                // [RL11] window lapsed, device programs now
                page_open_ff <= 1'b0;
                wc_cnt_ff <= PEB_CNT_W'(WRITE_CYCLE_CYC);
            end else begin
                busy <= 1'b0;
            end
        end
    end

    // pin drive, all from flops; [RL1] mode decode
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            chip_sel_n <= 1'b1;
            out_en_n <= 1'b1;
            wr_strobe_n <= 1'b1;
            data_oe_n <= 1'b1;
            mem_addr <= '0;
            data_out <= '0;
        end else if (clk_en) begin
            if (state_ff == PEB_IDLE && f_ready) begin
                mem_addr <= f_addr;
                data_out <= f_wdata;
                chip_sel_n <= 1'b0;
                out_en_n <= f_cmd[0];
                wr_strobe_n <= !f_cmd[0];
                data_oe_n <= !f_cmd[0];
            end else if ((state_ff == PEB_WR_LOW && cnt_zero) ||
                    (state_ff == PEB_RD && cnt_zero && !(cmd_ff ==
                    PEB_CMD_POLL && busy))) begin
                // [RL5] strobe rises, page stays open
                chip_sel_n <= 1'b1;
                out_en_n <= 1'b1;
                wr_strobe_n <= 1'b1;
                data_oe_n <= 1'b1;
            end else if (state_ff == PEB_RD && cnt_zero) begin
                chip_sel_n <= 1'b1;
                out_en_n <= 1'b1;
            end else if (state_ff == PEB_WAIT_WC && cnt_zero) begin
                chip_sel_n <= 1'b0;
                out_en_n <= 1'b0;
            end
        end
    end

    // answers and last toggle sample
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            rsp_done <= 1'b0;
            toggle_ff <= 1'b0;
            poll_armed_ff <= 1'b0;
        end else if (clk_en) begin
            rsp_valid <= 1'b0;
            rsp_done <= 1'b0;
            // a poll compares with a sample of its own, never a stale one
            if (state_ff == PEB_IDLE && f_ready) begin
                poll_armed_ff <= 1'b0;
            end
            if (state_ff == PEB_RD && cnt_zero) begin
                toggle_ff <= data_in[PEB_TOGGLE_BIT];
                poll_armed_ff <= 1'b1;
                if (!(cmd_ff == PEB_CMD_POLL && busy)) begin
                    rsp_valid <= 1'b1;
                    rsp_rdata <= data_in;
                end
            end
            if (state_ff == PEB_WR_HIGH && cnt_zero) begin
                rsp_done <= 1'b1;
            end
        end
    end
endmodule // peb_host

// *** verif/peb_eeprom_model.sv ***
`timescale 1ns/1ps
// behavioural memory device standing on the far side of the host pins
module peb_eeprom_model
    import peb_pkg::*;
#(
    parameter int WC_CYC = 120,
    parameter int BLC_CYC = 60
) (
    input wire logic sys_clk,
    input wire logic [PEB_ADDR_W-1:0] mem_addr,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic wr_strobe_n,
    input wire logic [PEB_DATA_W-1:0] data_out,
    output logic [PEB_DATA_W-1:0] data_in,
    output int viol
);
    logic [7:0] mem [131072];
    logic [7:0] last_ff = 8'h00;
    logic [7:0] wd_ff = 8'h00;
    logic [16:0] wa_ff = 17'h0_0000;
    logic [8:0] page_ff = 9'h000;
    logic wm_ff = 1'b0;
    logic oe_ff = 1'b1;
    logic tog_ff = 1'b0;
    logic rd, wm;
    int blc_ff = 0;
    int wc_ff = 0;
    int viol_ff = 0;
    // erased cells read as all ones
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
    end
    // mode decode; a pending page flips the toggle bit
    assign rd = !chip_sel_n && !out_en_n && wr_strobe_n;
    assign wm = !wr_strobe_n && !chip_sel_n && out_en_n;
    assign viol = viol_ff;
    always_comb begin
        data_in = ~last_ff; // no pull on the bus, so show the inverse
        if (rd) begin
            data_in = mem[mem_addr];
            if (blc_ff > 0 || wc_ff > 0) data_in[PEB_TOGGLE_BIT] = tog_ff;
        end
    end
    // loads, window and programming
    // a strobe too short to be sampled never commits; protection stays off
    always @(posedge sys_clk) begin
        wm_ff <= wm;
        oe_ff <= out_en_n;
        if (rd) last_ff <= data_in;
        if (out_en_n && !oe_ff && (blc_ff > 0 || wc_ff > 0)) tog_ff <= ~tog_ff;
        if (wm) begin
            wa_ff <= mem_addr;
            wd_ff <= data_out;
        end
        if (wc_ff > 0) wc_ff <= wc_ff - 1;
        if (wm_ff && !wm) begin
            // loads while programming or off the open page
            if (wc_ff > 0 || (blc_ff > 0 && wa_ff[16:8] != page_ff)) begin
                viol_ff <= viol_ff + 1;
            end else begin
                mem[wa_ff] <= wd_ff;
                page_ff <= wa_ff[16:8];
                blc_ff <= BLC_CYC;
            end
        end else if (blc_ff > 0) begin
            blc_ff <= blc_ff - 1;
            if (blc_ff == 1) wc_ff <= WC_CYC;
        end
    end
endmodule // peb_eeprom_model

// *** verif/peb_host_assertions.sv ***
`timescale 1ns/1ps
// pin-level watch on the host controller
module peb_host_assertions
    import peb_pkg::*;
#(
    parameter int POWERUP_CYC = PEB_POWERUP_CYC,
    parameter int BYTE_LOAD_CYC = PEB_BYTE_LOAD_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [PEB_ADDR_W-1:0] mem_addr,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic wr_strobe_n,
    input wire logic [PEB_DATA_W-1:0] data_out,
    input wire logic data_oe_n
);
    logic [PEB_CNT_W-1:0] up_ff, gap_ff;
    logic [8:0] page_ff;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // cycles since reset and since the last load; both saturate
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            up_ff <= '0;
            gap_ff <= '1;
            page_ff <= '0;
        end else begin
            if (up_ff != '1) up_ff <= up_ff + 1'b1;
            if (!wr_strobe_n) begin
                gap_ff <= '0;
                page_ff <= mem_addr[PEB_ADDR_W-1:PEB_PAGE_LSB];
            end else if (gap_ff != '1) begin
                gap_ff <= gap_ff + 1'b1;
            end
        end
    end
    a_write_decode: assert property (!wr_strobe_n |-> !chip_sel_n &&
        out_en_n && !data_oe_n) else $error("strobe outside write mode");
    a_read_decode: assert property (!out_en_n |-> !chip_sel_n &&
        wr_strobe_n && data_oe_n) else $error("read mode clash");
    a_standby_quiet: assert property (chip_sel_n |-> out_en_n &&
        wr_strobe_n && data_oe_n) else $error("deselected but active");
    a_powerup_hold: assert property (up_ff < POWERUP_CYC |->
        chip_sel_n) else $error("access before power-up delay");
    a_strobe_width: assert property ($fell(wr_strobe_n) |->
        !wr_strobe_n[*3]) else $error("strobe pulse too short");
    a_strobe_recover: assert property ($rose(wr_strobe_n) |->
        wr_strobe_n[*3]) else $error("strobe recovery too short");
    a_load_hold: assert property (!wr_strobe_n && !$past(wr_strobe_n)
        |-> $stable(data_out) && $stable(mem_addr)) else $error("load moved");
    a_read_length: assert property ($fell(out_en_n) |=>
        (!out_en_n && $stable(mem_addr))[*6]) else $error("read too short");
    a_page_fixed: assert property ($fell(wr_strobe_n) &&
        gap_ff < BYTE_LOAD_CYC |-> mem_addr[PEB_ADDR_W-1:PEB_PAGE_LSB] ==
        page_ff) else $error("page bits changed inside page");
    c_page_load: cover property ($fell(wr_strobe_n) && gap_ff < BYTE_LOAD_CYC);
    c_read_done: cover property ($rose(out_en_n));
    c_first_load: cover property ($fell(wr_strobe_n));
endmodule // peb_host_assertions
bind peb_host peb_host_assertions #(
    .POWERUP_CYC(POWERUP_CYC),
    .BYTE_LOAD_CYC(BYTE_LOAD_CYC)
) chk_u (.sys_clk(sys_clk), .rst(rst), .mem_addr(mem_addr),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
    .data_out(data_out), .data_oe_n(data_oe_n));

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin \
    miscompares++; $display("ERROR %0t got %h want %h", $time, a, e); \
    end end
module testbench
    import peb_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic req_valid = 1'b0;
    logic [1:0] req_cmd = 2'h0;
    logic [16:0] req_addr = 17'h0_0000;
    logic [7:0] req_wdata = 8'h00;
    logic req_ready, rsp_valid, rsp_done, busy;
    logic chip_sel_n, out_en_n, wr_strobe_n, data_oe_n;
    logic [7:0] rsp_rdata, data_in, data_out;
    logic [16:0] mem_addr;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    int viol, acc;
    // request, address, then data or the expected read value
    logic [26:0] rows [14] = '{
        {PEB_CMD_WRITE_LAST, 17'h0_0105, 8'ha5},
        {PEB_CMD_POLL, 17'h0_0105, 8'ha5}, {PEB_CMD_READ, 17'h0_0105, 8'ha5},
        {PEB_CMD_WRITE, 17'h0_0200, 8'h11}, {PEB_CMD_WRITE, 17'h0_0201, 8'h22},
        {PEB_CMD_WRITE_LAST, 17'h0_02ff, 8'h33},
        {PEB_CMD_POLL, 17'h0_02ff, 8'h33}, {PEB_CMD_READ, 17'h0_0200, 8'h11},
        {PEB_CMD_READ, 17'h0_0201, 8'h22}, {PEB_CMD_WRITE, 17'h0_0300, 8'h44},
        {PEB_CMD_WRITE_LAST, 17'h0_0400, 8'h55},
        {PEB_CMD_POLL, 17'h0_0400, 8'h55}, {PEB_CMD_READ, 17'h0_0300, 8'h44},
        {PEB_CMD_READ, 17'h1_ffff, 8'hff}};
    peb_host #(.POWERUP_CYC(20), .WRITE_CYCLE_CYC(200), .BYTE_LOAD_CYC(50))
    dut_u (.sys_clk, .rst, .clk_en, .req_valid, .req_ready, .req_cmd,
        .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .rsp_done, .busy,
        .mem_addr, .chip_sel_n, .out_en_n, .wr_strobe_n, .data_in, .data_out,
        .data_oe_n);
    peb_eeprom_model #(.WC_CYC(120), .BLC_CYC(60)) mdl_u (.sys_clk,
        .mem_addr, .chip_sel_n, .out_en_n, .wr_strobe_n, .data_out, .data_in,
        .viol);
    always #20 sys_clk = ~sys_clk;
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // the whole sequence needs a few thousand cycles at most
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            miscompares++;
            complete_run();
        end
    end
    // one request held until taken, then its answer under a bounded wait
    task automatic run(input logic [26:0] r);
        logic rd;
        int n;
        rd = r[26:25] inside {PEB_CMD_READ, PEB_CMD_POLL};
        req_cmd = r[26:25];
        req_addr = r[24:8];
        req_wdata = r[7:0];
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge sys_clk);
        @(negedge sys_clk);
        req_valid = 1'b0;
        for (n = 0; n < 3000; n++) begin
            if ((rd ? rsp_valid : rsp_done) === 1'b1) break;
            @(negedge sys_clk);
        end
        `CHK(n < 3000, 1'b1)
        if (rd) `CHK(rsp_rdata, r[7:0])
    endtask
    initial begin
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        `CHK({chip_sel_n,out_en_n,wr_strobe_n,data_oe_n,busy}, 5'h1e)
        // table of loads, polls and reads
        foreach (rows[i]) run(rows[i]);
        // loads pile up in the queue behind a running write cycle
        run({PEB_CMD_WRITE_LAST, 17'h0_0600, 8'h66});
        req_cmd = PEB_CMD_WRITE;
        req_valid = 1'b1;
        acc = 0;
        while (req_ready === 1'b1 && acc < 12) begin
            req_addr = 17'h0_0700 + 17'(acc);
            req_wdata = 8'(acc);
            @(negedge sys_clk);
            acc++;
        end
        req_valid = 1'b0;
        @(negedge sys_clk);
        `CHK(acc inside {8, 9}, 1'b1)
        run({PEB_CMD_WRITE_LAST, 17'h0_07ff, 8'h77});
        run({PEB_CMD_POLL, 17'h0_07ff, 8'h77});
        run({PEB_CMD_READ, 17'h0_0700, 8'h00});
        // clk_en low mid-read freezes pins and answer; the read then ends
        fork
            run({PEB_CMD_READ, 17'h0_0200, 8'h11});
            begin
                wait (out_en_n === 1'b0);
                @(negedge sys_clk);
                clk_en = 1'b0;
                repeat (20) @(negedge sys_clk);
                `CHK({chip_sel_n, out_en_n, rsp_valid}, 3'b000)
                clk_en = 1'b1;
            end
        join
        // second reset mid-run; stored data must survive it
        rst = 1'b1;
        @(negedge sys_clk);
        `CHK({chip_sel_n,out_en_n,wr_strobe_n,data_oe_n,req_ready}, 5'h1f)
        rst = 1'b0;
        run({PEB_CMD_READ, 17'h0_0201, 8'h22});
        `CHK(viol, 0)
        complete_run();
    end
endmodule // testbench
